// ### core/spc_engine.sv
`timescale 1ns/1ps
// What this block does
// R1: direct write loads low 10 bits into wiper
// R2: increment command adds one to wiper, holding at 0x3ff
// R3: store copies wiper into save slot
// R4: write protect low blocks nonvolatile changes
// R5: restore command reloads wiper from save slot
// R6: power-on and preset strobe also restore wiper
// R7: host sends no-op after restore
// R8: no-op returns engine to idle state
// R9: left-shift command doubles the wiper value
// R10: doubling past full scale clamps at 0x3ff
// R11: user store writes 16 bits to addressed slot; the code ignores a user store addressed to slot 0, the save slot
// R12: nonvolatile read prepares slot for next frame
// R13: next frame shifts out command, address, contents
// R14: wiper readback latches wiper for next frame
// R15: frame after readback ignored, returns wiper value
// R16: other frames echo previous frame one frame later
// R17: user slots hold 16 bits, store and read
// R18: wiper holds 10-bit code, 1024 positions
module spc_engine #(
    parameter int NV_DEPTH = spc_pkg::NV_DEPTH
) (
    // system
    input  wire logic       clk,
    input  wire logic       rst_n,
    // serial link pins
    input  wire logic       serialClk,
    input  wire logic       chipSelectN,
    input  wire logic       serialIn,
    output logic            serialOut,
    output logic            serialOutEn,
    // control pins
    input  wire logic       writeProtectN,
    input  wire logic       presetStrobeN,
    // state seen by the analog side
    output logic [9:0]      wiperCode,
    output logic            idleLowPower
);
    // reset release pipe
    logic [1:0]                 rstPipe;
    logic                       rstSyncN;
    // pin synchronisers, stage 1 then stage 2
    logic [4:0]                 pinMeta;
    logic [4:0]                 pinSync;
    // delayed copies for edge finding
    logic                       sclkDly;
    logic                       csDly;
    logic                       presetDly;
    // edge pulses
    logic                       sclkRise;
    logic                       sclkFall;
    logic                       csFall;
    logic                       csRise;
    logic                       presetFall;
    // frame reception
    logic [23:0]                rxShift;
    logic [4:0]                 bitCnt;
    logic                       frameDone;
    logic                       exec;
    logic [3:0]                 frameCmd;
    logic [3:0]                 frameAddr;
    // outgoing data
    logic [23:0]                txShift;
    logic [23:0]                lastFrame;
    logic [23:0]                prepWord;
    logic                       frameActive_reg;
    // core state
    logic [9:0]                 wiperReg;
    logic [15:0]                nvStore [NV_DEPTH];
    logic                       porPending_reg;
    spc_pkg::spc_state_e        state_reg;

    // clamp helpers used by the wiper logic only; the checks do not call them
    function automatic logic [9:0] incrSat(input logic [9:0] v);
        incrSat = (v == spc_pkg::WIPER_FULL) ? v : v + 10'h001;
    endfunction

    function automatic logic [9:0] doubleSat(input logic [9:0] v);
        doubleSat = v[9] ? spc_pkg::WIPER_FULL : {v[8:0], 1'b0};
    endfunction

    // reset released through two flops
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rstPipe <= 2'h0;
        else
            rstPipe <= {rstPipe[0], 1'b1};
    end
    assign rstSyncN = rstPipe[1];

    // all pins cross into clk before use
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            pinMeta <= 5'h1f;
            pinSync <= 5'h1f;
        end
        else
        begin
            pinMeta <= {presetStrobeN, writeProtectN, serialIn,
                        chipSelectN, serialClk};
            pinSync <= pinMeta;
        end
    end

    // edge detection looks only at the second stage
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            sclkDly   <= 1'b1;
            csDly     <= 1'b1;
            presetDly <= 1'b1;
        end
        else
        begin
            sclkDly   <= pinSync[0];
            csDly     <= pinSync[1];
            presetDly <= pinSync[4];
        end
    end

    assign sclkRise   = pinSync[0] & ~sclkDly & ~pinSync[1];
    assign sclkFall   = ~pinSync[0] & sclkDly & ~pinSync[1];
    assign csFall     = ~pinSync[1] & csDly;
    assign csRise     = pinSync[1] & ~csDly;
    assign presetFall = ~pinSync[4] & presetDly;

    // only whole 24-bit frames count; short or long ones are dropped
    assign frameDone = csRise & (bitCnt == spc_pkg::CNT_FULL_FRAME);
    // the frame after a read is only a carrier for the answer
    assign exec      = frameDone & (state_reg != spc_pkg::ST_READ_ARMED); // R15
    assign frameCmd  = rxShift[spc_pkg::CMD_MSB:spc_pkg::CMD_LSB];
    assign frameAddr = rxShift[spc_pkg::ADDR_MSB:spc_pkg::ADDR_LSB];

    // shift in serial_in on rising link clock, msb first
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            rxShift <= spc_pkg::WORD_RESET;
            bitCnt  <= spc_pkg::CNT_RESET;
        end
        else if (csFall)
        begin
            bitCnt <= spc_pkg::CNT_RESET;
        end
        else if (sclkRise)
        begin
            rxShift <= {rxShift[22:0], pinSync[2]};
            // saturate so an overlong frame never wraps to 24
            if (bitCnt != spc_pkg::CNT_SAT)
                bitCnt <= bitCnt + 5'h01;
        end
    end

    // keep last complete frame for the one-frame echo
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            lastFrame <= spc_pkg::WORD_RESET;
        else if (frameDone)
            lastFrame <= rxShift; // R16
    end

    // serial_out: load at frame start, shift on falling link clock
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            txShift         <= spc_pkg::WORD_RESET;
            frameActive_reg <= 1'b0;
        end
        else if (csFall)
        begin
            frameActive_reg <= 1'b1;
            // armed read answer, otherwise delayed echo
            if (state_reg == spc_pkg::ST_READ_ARMED)
                txShift <= prepWord; // R13
            else
                txShift <= lastFrame; // R16
        end
        else
        begin
            if (pinSync[1])
                frameActive_reg <= 1'b0;
            if (sclkFall)
                txShift <= {txShift[22:0], 1'b0};
        end
    end
    assign serialOut   = txShift[23];
    assign serialOutEn = frameActive_reg;

    // read answers are built when the read frame ends
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            prepWord <= spc_pkg::WORD_RESET;
        else if (exec && frameCmd == spc_pkg::CMD_NV_READ)
            prepWord <= {frameCmd, frameAddr, nvStore[frameAddr]}; // R12
        else if (exec && frameCmd == spc_pkg::CMD_WIPER_RD)
            prepWord <= {frameCmd, frameAddr, 6'h00, wiperReg}; // R14
    end

    // engine activity: restore leaves it busy until a no-op, or a read and its carrier frame; read until the next whole frame
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            state_reg <= spc_pkg::ST_IDLE;
        else if (frameDone)
        begin
            if (state_reg == spc_pkg::ST_READ_ARMED)
                state_reg <= spc_pkg::ST_IDLE;
            else
                unique case (frameCmd)
                    spc_pkg::CMD_NOP:      state_reg <= spc_pkg::ST_IDLE; // R8
                    spc_pkg::CMD_RESTORE:  state_reg <= spc_pkg::ST_RESTORED;
                    spc_pkg::CMD_NV_READ,
                    spc_pkg::CMD_WIPER_RD: state_reg <= spc_pkg::ST_READ_ARMED;
                    default:               state_reg <= state_reg;
                endcase
        end
    end

    // low-power flag for the analog side
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            idleLowPower <= 1'b1;
        else
            idleLowPower <= (state_reg == spc_pkg::ST_IDLE);
    end

    // power-on restore runs once right after reset release
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            porPending_reg <= 1'b1;
        else
            porPending_reg <= 1'b0;
    end

    // wiper register; preset and power-on win over a serial command
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
            wiperReg <= spc_pkg::WIPER_RESET;
        else if (porPending_reg || presetFall)
            wiperReg <= nvStore[spc_pkg::SLOT_WIPER_SAVE][9:0]; // R6
        else if (exec)
            unique case (frameCmd)
                spc_pkg::CMD_WRITE:    wiperReg <= rxShift[9:0]; // R1 R18
                spc_pkg::CMD_INCR:     wiperReg <= incrSat(wiperReg); // R2
                spc_pkg::CMD_SHIFT_UP: wiperReg <= doubleSat(wiperReg); // R9 R10
                spc_pkg::CMD_RESTORE:
                    wiperReg <= nvStore[spc_pkg::SLOT_WIPER_SAVE][9:0]; // R5
                default:               wiperReg <= wiperReg;
            endcase
    end
    assign wiperCode = wiperReg;

    // nonvolatile store, writes gated by write protect
    always_ff @(posedge clk or negedge rstSyncN)
    begin
        if (!rstSyncN)
        begin
            for (int i = 0; i < NV_DEPTH; i++)
                nvStore[i] <= (i == 0) ? spc_pkg::NV_SAVE_RESET
                                       : spc_pkg::NV_USER_RESET;
        end
        else if (exec && pinSync[3]) // R4
        begin
            if (frameCmd == spc_pkg::CMD_STORE)
                nvStore[spc_pkg::SLOT_WIPER_SAVE] <= {6'h00, wiperReg}; // R3
            else if (frameCmd == spc_pkg::CMD_USER_WR
                     && frameAddr != spc_pkg::SLOT_WIPER_SAVE)
                nvStore[frameAddr] <= rxShift[15:0]; // R11 R17
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstSyncN);

    sequence s_cmd(logic [3:0] c);
        exec && frameCmd == c && !presetFall && !porPending_reg;
    endsequence

    // start of the frame that carries an armed read answer
    sequence s_readArm;
        csFall && state_reg == spc_pkg::ST_READ_ARMED;
    endsequence

    a_write_loads: assert property ( // R1
        s_cmd(spc_pkg::CMD_WRITE) |=> wiperReg == $past(rxShift[9:0]))
        else $error("direct write did not load wiper");
    a_incr_step: assert property ( // R2
        s_cmd(spc_pkg::CMD_INCR) && wiperReg != spc_pkg::WIPER_FULL
        |=> wiperReg == $past(wiperReg) + 10'h001)
        else $error("increment did not add one");
    a_store_copy: assert property ( // R3
        exec && frameCmd == spc_pkg::CMD_STORE && pinSync[3]
        |=> nvStore[0] == {6'h00, $past(wiperReg)})
        else $error("store did not copy wiper");
    a_protect_holds: assert property ( // R4
        !pinSync[3] |=> $stable(nvStore[0]) && $stable(nvStore[2]))
        else $error("store changed while protected");
    a_restore_load: assert property ( // R5
        s_cmd(spc_pkg::CMD_RESTORE) |=> wiperReg == $past(nvStore[0][9:0]))
        else $error("restore did not reload wiper");
    a_preset_load: assert property ( // R6
        presetFall |=> wiperReg == $past(nvStore[0][9:0]))
        else $error("preset did not restore wiper");
    a_nop_idle: assert property ( // R8
        exec && frameCmd == spc_pkg::CMD_NOP
        |=> state_reg == spc_pkg::ST_IDLE ##1 idleLowPower)
        else $error("no-op did not return to idle");
    a_double_clamp: assert property ( // R10
        s_cmd(spc_pkg::CMD_SHIFT_UP) && wiperReg[9]
        |=> wiperReg == spc_pkg::WIPER_FULL)
        else $error("doubling did not clamp");
    a_read_answer: assert property ( // R13
        s_readArm |=> txShift == $past(prepWord) && serialOutEn)
        else $error("read answer not loaded");
    a_readback_word: assert property ( // R14
        exec && frameCmd == spc_pkg::CMD_WIPER_RD
        |=> prepWord[9:0] == $past(wiperReg)
            && prepWord[23:20] == spc_pkg::CMD_WIPER_RD)
        else $error("readback word wrong");
    a_echo_frame: assert property ( // R16
        csFall && state_reg != spc_pkg::ST_READ_ARMED
        |=> txShift == $past(lastFrame) && serialOutEn)
        else $error("echo word not loaded");
endmodule

// ### core/spc_pkg.sv
package spc_pkg;
    // frame layout: command nibble, address nibble, 16 data bits
    localparam int FRAME_BITS = 24;
    localparam int CMD_MSB    = 23;
    localparam int CMD_LSB    = 20;
    localparam int ADDR_MSB   = 19;
    localparam int ADDR_LSB   = 16;
    localparam int DATA_W     = 16;
    localparam int WIPER_W    = 10;
    localparam int NV_DEPTH   = 16;
    localparam int CNT_W      = 5;

    // command codes carried in the top nibble
    localparam logic [3:0] CMD_NOP      = 4'h0;
    localparam logic [3:0] CMD_RESTORE  = 4'h1;
    localparam logic [3:0] CMD_STORE    = 4'h2;
    localparam logic [3:0] CMD_USER_WR  = 4'h3;
    localparam logic [3:0] CMD_NV_READ  = 4'h9;
    localparam logic [3:0] CMD_WIPER_RD = 4'ha;
    localparam logic [3:0] CMD_WRITE    = 4'hb;
    localparam logic [3:0] CMD_SHIFT_UP = 4'hc;
    localparam logic [3:0] CMD_INCR     = 4'he;

    // nonvolatile slot addresses
    localparam logic [3:0] SLOT_WIPER_SAVE = 4'h0;
    localparam logic [3:0] SLOT_USER_ONE   = 4'h2;
    localparam logic [3:0] SLOT_USER_TWO   = 4'h3;

    // values after reset, plus full-scale and counter limits
    localparam logic [9:0]  WIPER_FULL      = 10'h3ff;
    localparam logic [9:0]  WIPER_RESET     = 10'h000;
    localparam logic [15:0] NV_SAVE_RESET   = 16'h0200;
    localparam logic [15:0] NV_USER_RESET   = 16'h0000;
    localparam logic [23:0] WORD_RESET      = 24'h000000;
    localparam logic [4:0]  CNT_RESET       = 5'h00;
    localparam logic [4:0]  CNT_FULL_FRAME  = 5'h18;
    localparam logic [4:0]  CNT_SAT         = 5'h1f;

    // command engine activity
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RESTORED,
        ST_READ_ARMED
    } spc_state_e;
endpackage

// ### verification/spc_host_model.sv
`timescale 1ns/1ps
// host side of the link; link clock rests low between frames
module spc_host_model (
    // pacing clock
    input  wire logic clk,
    // serial link pins
    output logic      serialClk,
    output logic      chipSelectN,
    output logic      serialIn,
    input  wire logic serialOut
);
    // idle levels at time zero
    initial
    begin
        serialClk = 1'b0;
        chipSelectN = 1'b1;
        serialIn = 1'b0;
    end
    // four clk per half period gives a 200 ns link clock
    task automatic half();
        repeat (4) @(negedge clk);
    endtask
    // one 24-bit frame msb first; answer bit taken before each rise
    task automatic xfer(input logic [23:0] tx, output logic [23:0] rx);
        chipSelectN = 1'b0;
        for (int i = 23; i >= 0; i--)
        begin
            serialIn = tx[i];
            half();
            rx[i] = serialOut;
            serialClk = 1'b1;
            half();
            serialClk = 1'b0;
        end
        half();
        chipSelectN = 1'b1;
        // a released data line must not keep showing its last bit
        serialIn = ~serialIn;
        half();
    endtask
endmodule

// ### verification/test_serial_pot_command_engine.sv
`timescale 1ns/1ps
module test_serial_pot_command_engine;
    logic        clk = 1'b0;    // system clock
    logic        rst_n;         // reset, active low
    logic        serialClk;     // link pins
    logic        chipSelectN;
    logic        serialIn;
    logic        serialOut;
    logic        serialOutEn;
    logic        writeProtectN; // control pins
    logic        presetStrobeN;
    logic [9:0]  wiperCode;     // observed state
    logic        idleLowPower;
    logic [23:0] rx;            // word returned by last frame
    int          errCount;
    int          numChecks;
    int          cycles = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    spc_engine dut (
        .clk(clk), .rst_n(rst_n), .serialClk(serialClk),
        .chipSelectN(chipSelectN), .serialIn(serialIn),
        .serialOut(serialOut), .serialOutEn(serialOutEn),
        .writeProtectN(writeProtectN), .presetStrobeN(presetStrobeN),
        .wiperCode(wiperCode), .idleLowPower(idleLowPower)
    );
    spc_host_model host (
        .clk(clk), .serialClk(serialClk), .chipSelectN(chipSelectN),
        .serialIn(serialIn), .serialOut(serialOut)
    );

    // counts and verdict, the single exit of the run
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", numChecks, errCount);
        if (errCount == 0 && numChecks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // compare a word, or a wiper code widened to a word
    task automatic chkWord(input logic [23:0] got, exp, input string m);
        numChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("CHECK FAILED %0t %s %h/%h", $time, m, got, exp);
        end
    endtask
    // compare a single flag
    task automatic chkFlag(input logic got, exp, input string m);
        numChecks++;
        if (got !== exp)
        begin
            errCount++;
            $display("CHECK FAILED %0t %s %b/%b", $time, m, got, exp);
        end
    endtask
    // one whole frame through the host
    task automatic send(input logic [23:0] w);
        host.xfer(w, rx);
    endtask
    // wiper widened so one compare serves words and codes
    function automatic logic [23:0] wip();
        return {14'h0000, wiperCode};
    endfunction

    // power-on restore and idle state
    task automatic tReset();
        chkWord(wip(), 24'h000200, "power-on");
        chkFlag(idleLowPower, 1'b1, "idle");
        chkFlag(serialOutEn, 1'b0, "out idle");
        $display("test reset done");
    endtask
    // direct write, then two increments with echoes
    task automatic tWriteIncr();
        // output enable looked at early in the first frame, 20 clk after it starts
        fork
            send(24'hb00100);
            begin
                repeat (20) @(negedge clk);
                chkFlag(serialOutEn, 1'b1, "out active");
            end
        join
        chkWord(wip(), 24'h000100, "write");
        chkFlag(serialOutEn, 1'b0, "out released");
        send(24'he00000);
        chkWord(rx, 24'hb00100, "echo");
        chkWord(wip(), 24'h000101, "incr");
        send(24'he0abcd);
        chkWord(rx, 24'he00000, "echo2");
        chkWord(wip(), 24'h000102, "incr2");
        $display("test write/incr done");
    endtask
    // store, restore, nop; then a store blocked by write protect
    task automatic tStore();
        send(24'h20abcd);
        send(24'hb00055);
        send(24'h100000);
        chkWord(wip(), 24'h000102, "restore");
        chkFlag(idleLowPower, 1'b0, "busy");
        send(24'h000000);
        chkWord(rx, 24'h100000, "echo");
        chkFlag(idleLowPower, 1'b1, "idle");
        writeProtectN = 1'b0;
        send(24'hb00007);
        send(24'h200000);
        send(24'h100000);
        send(24'h000000);
        chkWord(wip(), 24'h000102, "protect");
        writeProtectN = 1'b1;
        $display("test store done");
    endtask
    // preset strobe restores without a frame
    task automatic tPreset();
        send(24'hb00001);
        presetStrobeN = 1'b0;
        repeat (4) @(negedge clk);
        presetStrobeN = 1'b1;
        repeat (8) @(negedge clk);
        chkWord(wip(), 24'h000102, "preset");
        $display("test preset done");
    endtask
    // doubling, clamp at full scale, wiper readback
    task automatic tShift();
        send(24'hb00081);
        send(24'hc00000);
        chkWord(wip(), 24'h000102, "double");
        send(24'hb00200);
        send(24'hc00000);
        chkWord(wip(), 24'h0003ff, "clamp");
        send(24'ha00000);
        send(24'hb00000);
        chkWord(rx, 24'ha003ff, "readback");
        chkWord(wip(), 24'h0003ff, "ignored");
        send(24'he00000);
        chkWord(wip(), 24'h0003ff, "incr sat");
        $display("test shift done");
    endtask
    // user slots stored and read back in the next frame
    task automatic tUser();
        send(24'h32aaaa);
        send(24'h335555);
        chkWord(rx, 24'h32aaaa, "echo");
        send(24'h920000);
        chkFlag(idleLowPower, 1'b0, "busy");
        send(24'h000000);
        chkWord(rx, 24'h92aaaa, "read one");
        chkFlag(idleLowPower, 1'b1, "idle");
        send(24'h930000);
        send(24'h000000);
        chkWord(rx, 24'h935555, "read two");
        $display("test user done");
    endtask

    // cycle count for the hang guard
    always @(posedge clk)
        cycles++;

    // main sequence; the guard, about twice the expected run, races it
    initial
    begin
        errCount = 0;
        numChecks = 0;
        rst_n = 1'b0;
        writeProtectN = 1'b1;
        presetStrobeN = 1'b1;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
        repeat (14) @(negedge clk);
        fork
            begin
                tReset();
                tWriteIncr();
                tStore();
                tPreset();
                tShift();
                tUser();
            end
            begin
                wait (cycles == 10000);
                errCount++;
                $display("CHECK FAILED %0t timeout", $time);
            end
        join_any
        giveVerdict();
    end
endmodule
